// >>> src/tap_pkg.sv
// constants and types shared by the scan test port
package tap_pkg;

    // ********************************************************
    // register lengths
    // ********************************************************
    localparam int IR_LEN      = 3;
    localparam int BYPASS_LEN  = 1;
    localparam int ID_LEN      = 32;
    localparam int BSR_LEN     = 107;
    localparam int BSR_OE_CELL = 47;

    // ********************************************************
    // instruction codes
    // ********************************************************
    localparam logic [IR_LEN-1:0] INS_EXTEST  = 3'h0;
    localparam logic [IR_LEN-1:0] INS_IDCODE  = 3'h1;
    localparam logic [IR_LEN-1:0] INS_SAMPLEZ = 3'h2;
    localparam logic [IR_LEN-1:0] INS_SAMPLE  = 3'h4;
    localparam logic [IR_LEN-1:0] INS_BYPASS  = 3'h7;
    // fixed pattern loaded into the instruction shifter on capture
    localparam logic [IR_LEN-1:0] IR_CAPTURE  = 3'h1;

    // ********************************************************
    // identification word layout
    // ********************************************************
    localparam int ID_VER_MSB  = 31;
    localparam int ID_VER_LSB  = 29;
    localparam int ID_PART_MSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_VEND_MSB = 11;
    localparam int ID_VEND_LSB = 1;
    localparam int ID_MARK_BIT = 0;
    // the three identity values below are arbitrary
    localparam logic [2:0]  ID_VERSION = 3'h1;
    localparam logic [16:0] ID_PART    = 17'h0_A5A5;
    localparam logic [10:0] ID_VENDOR  = 11'h155;
    localparam logic        ID_MARK    = 1'h1;

    // ********************************************************
    // synchroniser and reset values
    // ********************************************************
    localparam logic [BSR_LEN-1:0] BSR_RESET = '0;
    localparam logic               BIT_CLEAR = 1'h0;

    // ********************************************************
    // controller states
    // ********************************************************
    typedef enum logic [3:0] {
        TLR, RTI,
        SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;

endpackage

// >>> src/tap_ctrl_if.sv
// carrier between the scan datapath and the controller state machine
`timescale 1ns/100ps
interface tap_ctrl_if;
    import tap_pkg::*;
    logic       tckRise;
    logic       tmsBit;
    tap_state_t state;

    modport fsm  (input tckRise, input tmsBit, output state);
    modport core (output tckRise, output tmsBit, input state);
endinterface

// >>> src/tap_fsm.sv
// sixteen-state test access controller
`timescale 1ns/100ps
module tap_fsm
    import tap_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic arst_n,
    tap_ctrl_if.fsm   ctrl
);

    tap_state_t stateReg;
    tap_state_t stateNext;

    // ********************************************************
    // next state, advanced by tms on each tck rise
    // ********************************************************
    always_comb begin
        stateNext = stateReg;
        if (ctrl.tckRise) begin
            case (stateReg)
                TLR:    stateNext = ctrl.tmsBit ? TLR    : RTI;
                RTI:    stateNext = ctrl.tmsBit ? SEL_DR : RTI;
                SEL_DR: stateNext = ctrl.tmsBit ? SEL_IR : CAP_DR;
                CAP_DR: stateNext = ctrl.tmsBit ? EX1_DR : SH_DR;
                SH_DR:  stateNext = ctrl.tmsBit ? EX1_DR : SH_DR;
                EX1_DR: stateNext = ctrl.tmsBit ? UPD_DR : PAU_DR;
                PAU_DR: stateNext = ctrl.tmsBit ? EX2_DR : PAU_DR;
                EX2_DR: stateNext = ctrl.tmsBit ? UPD_DR : SH_DR;
                UPD_DR: stateNext = ctrl.tmsBit ? SEL_DR : RTI;
                SEL_IR: stateNext = ctrl.tmsBit ? TLR    : CAP_IR;
                CAP_IR: stateNext = ctrl.tmsBit ? EX1_IR : SH_IR;
                SH_IR:  stateNext = ctrl.tmsBit ? EX1_IR : SH_IR;
                EX1_IR: stateNext = ctrl.tmsBit ? UPD_IR : PAU_IR;
                PAU_IR: stateNext = ctrl.tmsBit ? EX2_IR : PAU_IR;
                EX2_IR: stateNext = ctrl.tmsBit ? UPD_IR : SH_IR;
                UPD_IR: stateNext = ctrl.tmsBit ? SEL_DR : RTI;
                default: stateNext = TLR;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stateReg <= TLR;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign ctrl.state = stateReg;

    // ********************************************************
    // checks
    // ********************************************************
    a_state_only_rise: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !ctrl.tckRise |=> $stable(stateReg))
        else $error("state moved without a tck rise");

    a_shift_exit: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        ctrl.tckRise && ctrl.tmsBit && stateReg == SH_DR
        |=> stateReg == EX1_DR)
        else $error("shift-dr did not exit on tms high");

    a_reset_hold: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        ctrl.tckRise && ctrl.tmsBit && stateReg == TLR
        |=> stateReg == TLR)
        else $error("reset state left with tms high");

endmodule

// >>> src/sram_boundary_scan_tap.sv
// test access port: instruction decode, scan registers, output control
// Behaviour
// - code 000 captures ring, drives preloaded outputs
// - code 001 captures identity word, no side effect
// - code 010 captures ring, outputs high impedance
// - code 100 captures ring, memory unaffected
// - code 111 selects one-bit bypass register
// - identity word: version, part, vendor, marker one
// - tdo changes only after tck falls
// - tms and tdi sampled on tck rise
// - identity instruction current after reset state
// - cell 47 gates outputs under external test
// - msb next to tdi, lsb next to tdo
`timescale 1ns/100ps
module sram_boundary_scan_tap
    import tap_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               arst_n,
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    output logic                    tdo,
    output logic                    tdoEn,
    input  wire logic [BSR_LEN-1:0] ringIn,
    output logic      [BSR_LEN-1:0] ringDrive,
    output logic                    ringOverride,
    output logic                    memOutEn
);

    // ********************************************************
    // pin synchronisers and tck edge detection
    // ********************************************************
    logic               tckMeta;
    logic               tckSync;
    logic               tckPrev;
    logic               tmsMeta;
    logic               tmsSync;
    logic               tdiMeta;
    logic               tdiSync;
    logic [BSR_LEN-1:0] ringMeta;
    logic [BSR_LEN-1:0] ringSync;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tckMeta <= BIT_CLEAR;
            tckSync <= BIT_CLEAR;
            tckPrev <= BIT_CLEAR;
            tmsMeta <= BIT_CLEAR;
            tmsSync <= BIT_CLEAR;
            tdiMeta <= BIT_CLEAR;
            tdiSync <= BIT_CLEAR;
        end else begin
            tckMeta <= tck;
            tckSync <= tckMeta;
            tckPrev <= tckSync;
            tmsMeta <= tms;
            tmsSync <= tmsMeta;
            tdiMeta <= tdi;
            tdiSync <= tdiMeta;
        end
    end

    // ring pins may toggle near capture; value then undefined, not harmful
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ringMeta <= BSR_RESET;
            ringSync <= BSR_RESET;
        end else begin
            ringMeta <= ringIn;
            ringSync <= ringMeta;
        end
    end

    wire tckRise = tckSync & ~tckPrev;
    wire tckFall = ~tckSync & tckPrev;

    // ********************************************************
    // controller
    // ********************************************************
    tap_ctrl_if ctrl ();
    assign ctrl.tckRise = tckRise;
    assign ctrl.tmsBit  = tmsSync;

    tap_fsm fsm_i (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .ctrl    (ctrl.fsm)
    );

    tap_state_t state;
    assign state = ctrl.state;

    // ********************************************************
    // instruction decode
    // ********************************************************
    logic [IR_LEN-1:0]  irShift_reg;
    logic [IR_LEN-1:0]  irCur_reg;
    logic [BYPASS_LEN-1:0] bypass_reg;
    logic [ID_LEN-1:0]  idShift_reg;
    logic [BSR_LEN-1:0] bsrShift_reg;
    logic [BSR_LEN-1:0] bsrUpd_reg;

    wire selExtest  = (irCur_reg == INS_EXTEST);
    wire selId      = (irCur_reg == INS_IDCODE);
    wire selSampleZ = (irCur_reg == INS_SAMPLEZ);
    wire selSample  = (irCur_reg == INS_SAMPLE);
    wire selBsr     = selExtest | selSampleZ | selSample;
    // unused codes fall back to bypass so the chain stays one bit
    wire selBypass  = ~selId & ~selBsr;

    wire [ID_LEN-1:0] idValue = {ID_VERSION, ID_PART,
                                 ID_VENDOR, ID_MARK};

    wire riseCapDr = tckRise && state == CAP_DR;
    wire riseShDr  = tckRise && state == SH_DR;

    // ********************************************************
    // next values of the shifters, msb fed from tdi
    // ********************************************************
    wire [IR_LEN-1:0]  irShift_next  = {tdiSync, irShift_reg[IR_LEN-1:1]};
    wire [ID_LEN-1:0]  idShift_next  = {tdiSync, idShift_reg[ID_LEN-1:1]};
    wire [BSR_LEN-1:0] bsrShift_next =
        {tdiSync, bsrShift_reg[BSR_LEN-1:1]};

    // ********************************************************
    // instruction register
    // ********************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irShift_reg <= IR_CAPTURE;
        end else if (tckRise && state == CAP_IR) begin
            irShift_reg <= IR_CAPTURE;
        end else if (tckRise && state == SH_IR) begin
            irShift_reg <= irShift_next;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irCur_reg <= INS_IDCODE;
        end else if (state == TLR) begin
            irCur_reg <= INS_IDCODE;
        end else if (tckFall && state == UPD_IR) begin
            irCur_reg <= irShift_reg;
        end
    end

    // ********************************************************
    // data registers
    // ********************************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bypass_reg <= BIT_CLEAR;
        end else if (riseCapDr && selBypass) begin
            bypass_reg <= BIT_CLEAR;
        end else if (riseShDr && selBypass) begin
            bypass_reg <= tdiSync;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            idShift_reg <= '0;
        end else if (riseCapDr && selId) begin
            idShift_reg <= idValue;
        end else if (riseShDr && selId) begin
            idShift_reg <= idShift_next;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bsrShift_reg <= BSR_RESET;
        end else if (riseCapDr && selBsr) begin
            bsrShift_reg <= ringSync;
        end else if (riseShDr && selBsr) begin
            bsrShift_reg <= bsrShift_next;
        end
    end

    // preload latch; cleared in reset state so cell 47 starts low
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bsrUpd_reg <= BSR_RESET;
        end else if (state == TLR) begin
            bsrUpd_reg <= BSR_RESET;
        end else if (tckFall && state == UPD_DR && selBsr) begin
            bsrUpd_reg <= bsrShift_reg;
        end
    end

    // ********************************************************
    // serial output, moved on tck fall only
    // ********************************************************
    wire shiftIr = (state == SH_IR);
    wire shiftDr = (state == SH_DR);
    wire drLsb   = selId  ? idShift_reg[0] :
                   selBsr ? bsrShift_reg[0] : bypass_reg[0];
    wire tdoNext = shiftIr ? irShift_reg[0] : drLsb;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tdo   <= BIT_CLEAR;
            tdoEn <= BIT_CLEAR;
        end else if (tckFall) begin
            tdo   <= tdoNext;
            tdoEn <= shiftIr | shiftDr;
        end
    end

    // ********************************************************
    // memory output control
    // ********************************************************
    assign ringDrive    = bsrUpd_reg;
    assign ringOverride = selExtest;
    assign memOutEn     = selSampleZ ? 1'b0 :
                          selExtest  ? bsrUpd_reg[BSR_OE_CELL] :
                          1'b1;

    // ********************************************************
    // checks
    // ********************************************************
    a_reset_idcode: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        state == TLR |=> irCur_reg == INS_IDCODE)
        else $error("reset state did not restore identity read");

    a_id_capture: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        riseCapDr && selId |=> idShift_reg[ID_MARK_BIT] == ID_MARK
        && idShift_reg[ID_VER_MSB:ID_VER_LSB] == ID_VERSION
        && idShift_reg[ID_PART_MSB:ID_PART_LSB] == ID_PART
        && idShift_reg[ID_VEND_MSB:ID_VEND_LSB] == ID_VENDOR)
        else $error("identity word captured wrongly");

    a_samplez_hiz: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        irCur_reg == INS_SAMPLEZ |-> !memOutEn && !ringOverride)
        else $error("outputs not high impedance under sample z");

    a_extest_gate: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        irCur_reg == INS_EXTEST
        |-> ringOverride && memOutEn == bsrUpd_reg[BSR_OE_CELL])
        else $error("external test output gating wrong");

    a_sample_clear: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        irCur_reg == INS_SAMPLE || irCur_reg == INS_BYPASS
        |-> memOutEn && !ringOverride)
        else $error("memory disturbed by transparent instruction");

    a_bypass_shift: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        riseShDr && selBypass |=> bypass_reg[0] == $past(tdiSync))
        else $error("bypass bit did not take tdi");

    a_bsr_order: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        riseShDr && selBsr
        |=> bsrShift_reg[BSR_LEN-1] == $past(tdiSync)
        && bsrShift_reg[BSR_LEN-2:0] == $past(bsrShift_reg[BSR_LEN-1:1]))
        else $error("boundary shift order wrong");

    a_tdo_on_fall: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !tckFall |=> $stable(tdo) && $stable(tdoEn))
        else $error("tdo moved away from a tck fall");

endmodule

// >>> tb/scan_host.sv
// external scan controller model driving the test link
`timescale 1ns/100ps
module scan_host (
    input  wire logic ref_clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // ****************
    // one tck period: 8 ref_clk low, 8 high
    // ****************
    localparam int LOW_WAIT  = 7;
    localparam int HIGH_WAIT = 8;

    logic spare;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // pins set while tck low, held across the rise
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge ref_clk);
        tms <= m;
        tdi <= d;
        repeat (LOW_WAIT) @(posedge ref_clk);
        o = tdo; // settled since the fall
        tck <= 1'b1;
        repeat (HIGH_WAIT) @(posedge ref_clk);
        tck <= 1'b0; // tck stands low between calls
    endtask

    // data line not shifted: inverse of last value, never a stale copy
    task automatic move(input logic m);
        step(m, ~tdi, spare);
    endtask

    // ****************
    // state walks
    // ****************
    // stay in run-test-idle
    task automatic idle();
        move(1'b0);
    endtask

    // run-test-idle to shift-ir
    task automatic toShiftIr();
        move(1'b1);
        move(1'b1);
        move(1'b0);
        move(1'b0);
    endtask

    // run-test-idle to shift-dr
    task automatic toShiftDr();
        move(1'b1);
        move(1'b0);
        move(1'b0);
    endtask

    // exit1 through update back to run-test-idle
    task automatic toIdle();
        move(1'b1);
        move(1'b0);
    endtask

    // five tms highs reach reset from anywhere
    task automatic toReset();
        repeat (5) move(1'b1);
    endtask
endmodule

// >>> tb/test_sram_boundary_scan_tap.sv
// self-checking bench for the scan test port
`timescale 1ns/100ps
module test_sram_boundary_scan_tap;
    import tap_pkg::*;
    logic               ref_clk;
    logic               arst_n;
    logic               tck;
    logic               tms;
    logic               tdi;
    logic               tdo;
    logic               tdoEn;
    logic               ringOverride;
    logic               memOutEn;
    logic [BSR_LEN-1:0] ringIn;
    logic [BSR_LEN-1:0] ringDrive;
    logic [BSR_LEN-1:0] expDrive;
    logic [ID_LEN-1:0]  idWord;
    logic [IR_LEN-1:0]  curCode;
    logic [5*IR_LEN-1:0] legalCodes;
    int                 pick;
    logic               q[$];
    int                 errCount;
    int                 nCompared;
    int                 cycles;

    assign idWord = {ID_VERSION, ID_PART, ID_VENDOR, ID_MARK};
    assign legalCodes = {INS_BYPASS, INS_SAMPLE, INS_SAMPLEZ,
                         INS_IDCODE, INS_EXTEST};

    sram_boundary_scan_tap dut (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .tck          (tck),
        .tms          (tms),
        .tdi          (tdi),
        .tdo          (tdo),
        .tdoEn        (tdoEn),
        .ringIn       (ringIn),
        .ringDrive    (ringDrive),
        .ringOverride (ringOverride),
        .memOutEn     (memOutEn)
    );

    scan_host host (
        .ref_clk (ref_clk),
        .tck (tck),
        .tms (tms),
        .tdi (tdi),
        .tdo (tdo)
    );

    // ****************
    // clock, timeout, helpers
    // ****************
    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errCount++;
            wrapUp();
        end
    end

    // tdo may only move while tck is low
    always @(tdo) begin
        if (arst_n === 1'b1 && tck === 1'b1) begin
            errCount++;
            $display("MISMATCH t=%0t tdo=%h tck=%h", $time, tdo, tck);
        end
    end

    task automatic wrapUp();
        if (errCount == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [BSR_LEN-1:0] got,
                         input logic [BSR_LEN-1:0] exp);
        nCompared++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic checkOut(input logic [2:0] code);
        logic en;
        en = (code == INS_SAMPLEZ) ? 1'b0 :
             (code == INS_EXTEST) ? expDrive[BSR_OE_CELL] : 1'b1;
        check(ringDrive, expDrive);
        check(ringOverride, code == INS_EXTEST);
        check(memOutEn, en);
        check(tdoEn, 1'b0);
    endtask

    // from run-test-idle to run-test-idle; captured pattern shifts out
    task automatic loadIr(input logic [2:0] code);
        logic o;
        host.toShiftIr();
        for (int i = 0; i < IR_LEN; i++) begin
            host.step(i == IR_LEN - 1, code[i], o);
            check(o, IR_CAPTURE[i]);
        end
        host.toIdle();
        #100;
    endtask

    // model register as a queue, lsb at the front
    task automatic scanDr(input logic [2:0] code);
        logic               o;
        logic               d;
        logic               exp;
        logic [BSR_LEN-1:0] cap;
        int                 len;
        int                 n;
        len = (code inside {INS_EXTEST, INS_SAMPLEZ, INS_SAMPLE}) ?
              BSR_LEN : (code == INS_IDCODE) ? ID_LEN : BYPASS_LEN;
        cap = (len == BSR_LEN) ? ringIn :
              (len == ID_LEN) ? BSR_LEN'(idWord) : '0;
        n = BSR_LEN + 4;
        q.delete();
        for (int k = 0; k < len; k++) begin
            q.push_back(cap[k]);
        end
        host.toShiftDr();
        for (int i = 0; i < n; i++) begin
            d = 1'($urandom_range(1, 0));
            // lands in cell 47 so external test gets to drive
            if (code == INS_EXTEST && i == 4 + BSR_OE_CELL) begin
                d = 1'b1;
            end
            host.step(i == n - 1, d, o);
            exp = q.pop_front();
            q.push_back(d);
            check({tdoEn, o}, {1'b1, exp});
        end
        if (len == BSR_LEN) begin
            for (int k = 0; k < len; k++) begin
                expDrive[k] = q[k];
            end
        end
        host.toIdle();
        #100;
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        void'($urandom(32'h8ee7947c));
        ref_clk = 1'b0;
        arst_n = 1'b0;
        ringIn = '0;
        expDrive = '0;
        errCount = 0;
        nCompared = 0;
        cycles = 0;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #3;
        checkOut(INS_IDCODE);
        host.idle();
        scanDr(INS_IDCODE);
        checkOut(INS_IDCODE);
        // reserved codes never sent: a random legal code takes the slot
        for (int c = 0; c < 8; c++) begin
            curCode = 3'(c);
            if (c == 3 || c == 5 || c == 6) begin
                pick = $urandom_range(4, 0);
                curCode = legalCodes[pick*IR_LEN +: IR_LEN];
            end
            @(posedge ref_clk);
            for (int k = 0; k < BSR_LEN; k++) begin
                ringIn[k] <= 1'($urandom_range(1, 0));
            end
            #3;
            loadIr(curCode);
            checkOut(curCode);
            scanDr(curCode);
            checkOut(curCode);
        end
        host.toReset();
        #100;
        expDrive = '0;
        checkOut(INS_IDCODE);
        host.idle();
        scanDr(INS_IDCODE);
        wrapUp();
    end
endmodule
